// ---- pkg/vpdo_pkg.sv ----
package vpdo_pkg;
  // Frame identifier bases, node number added to all but ID_SYNC
  localparam logic [10:0] ID_SYNC  = 11'h080;
  localparam logic [10:0] ID_FAST  = 11'h200;
  localparam logic [10:0] ID_SLOW1 = 11'h300;
  localparam logic [10:0] ID_SLOW2 = 11'h400;
  localparam logic [10:0] ID_REPLY = 11'h180;
  localparam logic [10:0] ID_VT    = 11'h280;
  localparam logic [10:0] ID_EFF   = 11'h380;
  localparam logic [10:0] ID_CUR   = 11'h480;
  localparam logic [10:0] ID_POS   = 11'h1E0;
  localparam logic [10:0] ID_DIAG  = 11'h2E0;
  // Payload lengths
  localparam logic [3:0]  LEN_FAST = 4'h3;
  localparam logic [3:0]  LEN_FULL = 4'h8;
  // Command byte bit positions
  localparam int CMD_TRIP   = 0;
  localparam int CMD_CLEAR  = 1;
  localparam int CMD_TEST   = 2;
  localparam int CMD_ANFIRST = 3;
  localparam int CMD_ANFALL = 4;
  // Demand raw value for 0 %
  localparam logic [15:0] DEMAND_ZERO = 16'h09C4;
  localparam logic [15:0] PICK_MAX    = 16'h0002;
  // Node number limit with frames five and six
  localparam logic [7:0]  NODE_MAX56  = 8'h1F;
  // Timing
  localparam int CLK_NS  = 40;
  localparam int MS_NS   = 1000000;
  localparam int GAP_MS  = 2;
  localparam int MS_CYC  = MS_NS / CLK_NS;
  localparam int GAP_CYC = GAP_MS * MS_CYC;
  // Register map
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_TIMEOUT = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_DIAG12  = 8'h0C;
  localparam logic [7:0]  OFS_DIAG3   = 8'h10;
  localparam int CTRL_EN56 = 8;
  localparam int STAT_LINK = 8;
  localparam int STAT_SLOW = 9;
  localparam logic [7:0]  RST_NODE    = 8'h01;
  localparam logic [15:0] RST_TIMEOUT = 16'h0028;
  // Diagnostic word 2 internal bit positions
  localparam int D2_SLOW = 4;
  localparam int D2_ANHI = 5;
  localparam int D2_ANLO = 6;
  localparam int D2_BOOT = 7;
  localparam int D2_LINK = 10;
  localparam int D2_TRACK = 12;
endpackage

// ---- design/vpdo_codec.sv ----
`timescale 1ns/1ns
module vpdo_codec
  import vpdo_pkg::*;
#(
  parameter int MS_CYCLES  = MS_CYC,
  parameter int GAP_CYCLES = GAP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Received frames
  input  wire logic        rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic [3:0]  rx_len_i,
  input  wire logic [63:0] rx_data_i,
  // Transmit frames
  output logic             tx_valid_o,
  output logic [10:0]      tx_id_o,
  output logic [3:0]       tx_len_o,
  output logic [63:0]      tx_data_o,
  input  wire logic        tx_ready_i,
  // Device state and telemetry
  input  wire logic        op_state_i,
  input  wire logic [15:0] meas_pos_i,
  input  wire logic [31:0] supply_volt_i,
  input  wire logic [31:0] temp_kelvin_i,
  input  wire logic [31:0] efficiency_i,
  input  wire logic [31:0] analog_in_i,
  input  wire logic [31:0] drive_amp_i,
  input  wire logic [31:0] drive_amp_filt_i,
  input  wire logic [31:0] sensor_a_pos_i,
  input  wire logic [31:0] sensor_b_pos_i,
  // Fault sources
  input  wire logic [10:0] fault1_i,
  input  wire logic [15:0] fault2_i,
  input  wire logic [2:0]  fault3_i,
  input  wire logic        alarm_i,
  input  wire logic        pos_trip_i,
  // Decoded demand and configuration
  output logic [15:0]      demand_o,
  output logic             trip_cmd_o,
  output logic             sensor_test_running_o,
  output logic             analog_first_select_o,
  output logic             analog_fallback_enable_o,
  output logic [31:0]      track_tolerance_o,
  output logic [15:0]      track_window_ms_o,
  output logic [1:0]       sensor_pick_mode_o,
  output logic [31:0]      sensor_gap_limit_a_o,
  output logic [31:0]      sensor_gap_limit_b_o
);

  typedef enum logic [2:0] {C_IDLE, C_VT, C_EFF, C_CUR, C_POS, C_DIAG} vpdo_chain_t;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  node;
  logic        en56;
  logic [15:0] tmo_ms;
  logic        clr_prev;
  logic        trip_latch;
  logic        boot_hold;
  logic        link_fault;
  logic        slow_missing;
  logic        seen1;
  logic        seen2;
  logic [10:0] diag1;
  logic [15:0] diag2_ext;
  logic [2:0]  diag3;
  logic [15:0] sync_age;
  logic [15:0] fast_age;
  logic [15:0] ms_pre;
  logic [16:0] gap_cnt;
  logic        rep_pend;
  logic        test_cmd;
  vpdo_chain_t chain;

  ////////////////////////////////////////////////////////////////////////
  // Frame decode
  wire [10:0] node11  = {3'h0, node};
  wire rx_sync   = rx_valid_i && rx_id_i == ID_SYNC;
  wire rx_fast_h = rx_valid_i && rx_id_i == ID_FAST + node11;
  wire rx_fast   = rx_fast_h && rx_len_i >= LEN_FAST;
  wire rx_slow1  = rx_valid_i && rx_id_i == ID_SLOW1 + node11 && rx_len_i >= LEN_FULL;
  wire rx_slow2  = rx_valid_i && rx_id_i == ID_SLOW2 + node11 && rx_len_i >= LEN_FULL;
  wire [15:0] rx_dem  = rx_data_i[15:0];
  wire [7:0]  rx_cmd  = rx_data_i[23:16];
  wire [15:0] rx_pick = rx_data_i[63:48];
  wire clr_evt   = rx_fast && rx_cmd[CMD_CLEAR] && !clr_prev;
  wire pick_ok   = rx_pick <= PICK_MAX;

  ////////////////////////////////////////////////////////////////////////
  // Timeout supervision
  wire ms_tick   = ms_pre == 16'(MS_CYCLES - 1);
  wire tmo_on    = op_state_i && tmo_ms != 16'h0000;
  wire link_loss = tmo_on && (sync_age >= tmo_ms || fast_age >= tmo_ms);

  ////////////////////////////////////////////////////////////////////////
  // Flags and status
  wire an_mask  = analog_fallback_enable_o;
  wire [15:0] f2_in = fault2_i & {3'h7, an_mask, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
                                  an_mask, an_mask, 1'b0, 4'hF};
  wire [15:0] diag2 = {diag2_ext[15:13], diag2_ext[12], 1'b0, link_fault,
                       diag2_ext[9:8], boot_hold, diag2_ext[6:5], slow_missing,
                       diag2_ext[3:0]};
  wire sys_trip = |diag1;
  wire pos_trip = pos_trip_i || diag2_ext[2];
  wire alarm    = alarm_i || diag3[0] || diag3[1];
  wire all_trip = trip_latch || boot_hold || sys_trip || pos_trip || diag3[2]
                  || diag2_ext[9] || link_fault;
  wire test_run = test_cmd && demand_o <= DEMAND_ZERO;
  wire [7:0] status = {3'h0, test_run, all_trip, pos_trip,
                       sys_trip, alarm};

  wire [10:0] next_diag1 = clr_evt ? fault1_i : diag1 | fault1_i;
  wire [15:0] next_diag2 = clr_evt ? f2_in : diag2_ext | f2_in;
  wire [2:0]  next_diag3 = clr_evt ? fault3_i : diag3 | fault3_i;
  wire next_trip  = (rx_fast && rx_cmd[CMD_TRIP]) || (trip_latch && !clr_evt);
  wire next_link  = link_loss || (link_fault && !clr_evt);
  wire next_seen1 = !link_loss && (seen1 || rx_slow1);
  wire next_seen2 = !link_loss && (seen2 || rx_slow2);
  wire next_slow  = !(next_seen1 && next_seen2);

  ////////////////////////////////////////////////////////////////////////
  // Transmit frame selection
  wire node_ok56 = en56 && node != 8'h00 && node <= NODE_MAX56;
  wire chain_due = chain != C_IDLE && gap_cnt == 17'h00000;
  wire load_rep  = !tx_valid_o && rep_pend;
  wire load_ch   = !tx_valid_o && !rep_pend && chain_due;
  logic [10:0] ch_base;
  logic [63:0] ch_data;
  vpdo_chain_t ch_next;
  always_comb begin
    ch_base = ID_VT;
    ch_data = {temp_kelvin_i, supply_volt_i};
    ch_next = C_EFF;
    unique case (chain)
      C_IDLE: begin
        ch_next = C_IDLE;
      end
      C_VT: begin
        ch_next = C_EFF;
      end
      C_EFF: begin
        ch_base = ID_EFF;
        ch_data = {analog_in_i, efficiency_i};
        ch_next = C_CUR;
      end
      C_CUR: begin
        ch_base = ID_CUR;
        ch_data = {drive_amp_filt_i, drive_amp_i};
        ch_next = node_ok56 ? C_POS : C_IDLE;
      end
      C_POS: begin
        ch_base = ID_POS;
        ch_data = {sensor_b_pos_i, sensor_a_pos_i};
        ch_next = C_DIAG;
      end
      C_DIAG: begin
        ch_base = ID_DIAG;
        ch_data = {16'h0000, 13'h0000, diag3, diag2, 5'h00, diag1};
        ch_next = C_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_acc  = psel_i && penable_i && pready_o;
  wire apb_wr   = apb_acc && pwrite_i;
  wire hit_ctrl = paddr_i == OFS_CTRL;
  wire hit_tmo  = paddr_i == OFS_TIMEOUT;
  wire hit_any  = hit_ctrl || hit_tmo || paddr_i == OFS_STATUS
                  || paddr_i == OFS_DIAG12 || paddr_i == OFS_DIAG3;
  wire [31:0] rd_mux =
      hit_ctrl ? {23'h0, en56, node} :
      hit_tmo  ? {16'h0000, tmo_ms} :
      paddr_i == OFS_STATUS ? {22'h0, slow_missing, link_fault, status} :
      paddr_i == OFS_DIAG12 ? {diag2, 5'h00, diag1} :
      paddr_i == OFS_DIAG3  ? {demand_o, 13'h0000, diag3} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit_any;
      prdata_o  <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      node   <= RST_NODE;
      en56   <= 1'b0;
      tmo_ms <= RST_TIMEOUT;
    end else if (apb_wr && hit_ctrl) begin
      node <= pwdata_i[7:0];
      en56 <= pwdata_i[CTRL_EN56];
    end else if (apb_wr && hit_tmo) begin
      tmo_ms <= pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received values
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      demand_o                 <= 16'h0000;
      trip_cmd_o               <= 1'b0;
      test_cmd                 <= 1'b0;
      clr_prev                 <= 1'b0;
      analog_first_select_o    <= 1'b0;
      analog_fallback_enable_o <= 1'b0;
    end else if (rx_fast) begin
      demand_o                 <= rx_dem;
      trip_cmd_o               <= rx_cmd[CMD_TRIP];
      test_cmd                 <= rx_cmd[CMD_TEST];
      clr_prev                 <= rx_cmd[CMD_CLEAR];
      analog_first_select_o    <= rx_cmd[CMD_ANFIRST];
      analog_fallback_enable_o <= rx_cmd[CMD_ANFALL];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      track_tolerance_o  <= 32'h00000000;
      track_window_ms_o  <= 16'h0000;
      sensor_pick_mode_o <= 2'h0;
    end else if (rx_slow1) begin
      track_tolerance_o <= rx_data_i[31:0];
      track_window_ms_o <= rx_data_i[47:32];
      if (pick_ok) begin
        sensor_pick_mode_o <= rx_pick[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sensor_gap_limit_a_o <= 32'h00000000;
      sensor_gap_limit_b_o <= 32'h00000000;
    end else if (rx_slow2) begin
      sensor_gap_limit_a_o <= rx_data_i[31:0];
      sensor_gap_limit_b_o <= rx_data_i[63:32];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic and shutdown state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      diag1        <= 11'h000;
      diag2_ext    <= 16'h0000;
      diag3        <= 3'h0;
      trip_latch   <= 1'b0;
      boot_hold    <= 1'b1;
      link_fault   <= 1'b0;
      seen1        <= 1'b0;
      seen2        <= 1'b0;
      slow_missing <= 1'b1;
      sensor_test_running_o <= 1'b0;
    end else begin
      diag1        <= next_diag1;
      diag2_ext    <= next_diag2;
      diag3        <= next_diag3;
      trip_latch   <= next_trip;
      boot_hold    <= boot_hold && !clr_evt;
      link_fault   <= next_link;
      seen1        <= next_seen1;
      seen2        <= next_seen2;
      slow_missing <= next_slow;
      sensor_test_running_o <= test_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond timing
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_pre   <= 16'h0000;
      sync_age <= 16'h0000;
      fast_age <= 16'h0000;
    end else begin
      ms_pre <= ms_tick ? 16'h0000 : ms_pre + 16'h0001;
      if (!tmo_on || rx_sync) begin
        sync_age <= 16'h0000;
      end else if (ms_tick && sync_age != 16'hFFFF) begin
        sync_age <= sync_age + 16'h0001;
      end
      if (!tmo_on || rx_fast) begin
        fast_age <= 16'h0000;
      end else if (ms_tick && fast_age != 16'hFFFF) begin
        fast_age <= fast_age + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencing
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rep_pend <= 1'b0;
      chain    <= C_IDLE;
      gap_cnt  <= 17'h00000;
    end else begin
      rep_pend <= rx_fast || (rep_pend && !load_rep);
      if (rx_slow1) begin
        chain   <= C_VT;
        gap_cnt <= 17'h00000;
      end else if (load_ch) begin
        chain   <= ch_next;
        gap_cnt <= 17'(GAP_CYCLES - 1);
      end else if (gap_cnt != 17'h00000) begin
        gap_cnt <= gap_cnt - 17'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_id_o    <= 11'h000;
      tx_len_o   <= 4'h0;
      tx_data_o  <= 64'h0000000000000000;
    end else if (load_rep) begin
      tx_valid_o <= 1'b1;
      tx_id_o    <= ID_REPLY + node11;
      tx_len_o   <= LEN_FAST;
      tx_data_o  <= {40'h0000000000, status, meas_pos_i};
    end else if (load_ch) begin
      tx_valid_o <= 1'b1;
      tx_id_o    <= ch_base + node11;
      tx_len_o   <= LEN_FULL;
      tx_data_o  <= ch_data;
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

endmodule

// ---- testbench/vpdo_codec_sva.sv ----
`timescale 1ns/1ns
module vpdo_codec_chk
  import vpdo_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // Bus answer
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Frames
  input wire logic        rx_valid_i,
  input wire logic [3:0]  rx_len_i,
  input wire logic [63:0] rx_data_i,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic [10:0] tx_id_o,
  input wire logic [3:0]  tx_len_o,
  input wire logic [63:0] tx_data_o,
  // Decoded values
  input wire logic [15:0] demand_o,
  input wire logic        trip_cmd_o,
  input wire logic        sensor_test_running_o,
  input wire logic [15:0] track_window_ms_o,
  input wire logic [1:0]  sensor_pick_mode_o,
  input wire logic [31:0] sensor_gap_limit_a_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_id_o)) else $error("tx frame dropped early");
  reply_zero_a: assert property (tx_valid_o && tx_len_o == LEN_FAST |->
    tx_data_o[63:21] == 43'h0) else $error("reply reserved bits set");
  test_gate_a: assert property (sensor_test_running_o |->
    $past(demand_o) <= DEMAND_ZERO) else $error("sensor test above zero demand");
  demand_src_a: assert property (!$stable(demand_o) |-> $past(rx_valid_i) &&
    $past(rx_len_i) >= LEN_FAST && demand_o == $past(rx_data_i[15:0]))
    else $error("demand changed without fast frame");
  short_drop_a: assert property (rx_valid_i && rx_len_i < LEN_FAST |=>
    $stable(demand_o) && $stable(trip_cmd_o)) else $error("short frame taken");
  pick_code_a: assert property (!$stable(sensor_pick_mode_o) |->
    $past(rx_data_i[63:48]) <= PICK_MAX && sensor_pick_mode_o == $past(rx_data_i[49:48]))
    else $error("bad pick code taken");
  window_load_a: assert property (!$stable(track_window_ms_o) |-> $past(rx_valid_i) &&
    $past(rx_len_i) >= LEN_FULL && track_window_ms_o == $past(rx_data_i[47:32]))
    else $error("tracking window wrong");
  gap_load_a: assert property (!$stable(sensor_gap_limit_a_o) |-> $past(rx_valid_i) &&
    sensor_gap_limit_a_o == $past(rx_data_i[31:0])) else $error("gap limit wrong");
  diag_resv_a: assert property (tx_valid_o && tx_id_o[10:5] == 6'h17 |->
    tx_data_o[15:11] == 5'h0 && tx_data_o[47:35] == 13'h0 && tx_data_o[63:48] == 16'h0)
    else $error("diagnostic reserved bits set");
  reply_c: cover property (tx_valid_o && tx_ready_i && tx_len_o == LEN_FAST);
  diag_c: cover property (tx_valid_o && tx_ready_i && tx_id_o[10:5] == 6'h17);
  err_c: cover property (pready_o && pslverr_o);
endmodule
bind vpdo_codec vpdo_codec_chk i_chk (.ref_clk_i, .rst_i, .pready_o, .pslverr_o, .rx_valid_i,
  .rx_len_i, .rx_data_i, .tx_valid_o, .tx_ready_i, .tx_id_o, .tx_len_o, .tx_data_o, .demand_o,
  .trip_cmd_o, .sensor_test_running_o, .track_window_ms_o, .sensor_pick_mode_o,
  .sensor_gap_limit_a_o);

// ---- testbench/vpdo_master_model.sv ----
`timescale 1ns/1ns
module vpdo_master_model
  import vpdo_pkg::*;
(
  // Clock and control
  input  wire logic        ref_clk_i,
  input  wire logic        stall_i,
  // Frames to the codec
  output logic             rx_valid_o,
  output logic [10:0]      rx_id_o,
  output logic [3:0]       rx_len_o,
  output logic [63:0]      rx_data_o,
  // Frames from the codec
  input  wire logic        tx_valid_i,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [3:0]  tx_len_i,
  input  wire logic [63:0] tx_data_i,
  output logic             tx_ready_o
);
  logic [10:0] id_q[$];
  logic [3:0]  len_q[$];
  logic [63:0] dat_q[$];
  int          cyc_q[$];
  int          cyc = 0;
  logic [1:0]  slot = 2'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 11'h0;
    rx_len_o = 4'h0;
    rx_data_o = 64'h0;
    tx_ready_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Takes a frame every fourth cycle while stalled
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    slot <= slot + 2'h1;
    tx_ready_o <= !stall_i || slot == 2'h2;
    if (tx_valid_i && tx_ready_o) begin
      id_q.push_back(tx_id_i);
      len_q.push_back(tx_len_i);
      dat_q.push_back(tx_data_i);
      cyc_q.push_back(cyc);
    end
  end
  task send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_len_o <= len;
    rx_data_o <= d;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
  task fast(input logic [7:0] node, input logic [15:0] dem, input logic [4:0] cmd,
            input logic [3:0] len);
    send(ID_FAST + {3'h0, node}, len, {40'h0, 3'b000, cmd, dem});
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
  import vpdo_pkg::*;
;
  localparam int MSC  = 10;
  localparam int GAPC = 20;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, tol, gapa, gapb, flt [8];
  logic        pready, pslverr, rx_valid, tx_valid, tx_ready, stall = 1'b0, op_state = 1'b0;
  logic [10:0] rx_id, tx_id, fault1 = 11'h0;
  logic [3:0]  rx_len, tx_len;
  logic [63:0] rx_data, tx_data;
  logic [15:0] meas = 16'hF424, fault2 = 16'h0, demand, twin;
  logic [2:0]  fault3 = 3'h0;
  logic        trip, test_run, an_first, an_fall;
  logic [1:0]  pick;
  int          mismatches = 0, checked = 0;
  initial forever #20 clk = ~clk;
  vpdo_codec #(.MS_CYCLES(MSC), .GAP_CYCLES(GAPC)) i_dut (.ref_clk_i(clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_len_i(rx_len), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_id_o(tx_id), .tx_len_o(tx_len), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .op_state_i(op_state), .meas_pos_i(meas),
    .supply_volt_i(flt[0]), .temp_kelvin_i(flt[1]), .efficiency_i(flt[2]),
    .analog_in_i(flt[3]), .drive_amp_i(flt[4]), .drive_amp_filt_i(flt[5]),
    .sensor_a_pos_i(flt[6]), .sensor_b_pos_i(flt[7]), .fault1_i(fault1), .fault2_i(fault2),
    .fault3_i(fault3), .alarm_i(1'b0), .pos_trip_i(1'b0), .demand_o(demand),
    .trip_cmd_o(trip), .sensor_test_running_o(test_run), .analog_first_select_o(an_first),
    .analog_fallback_enable_o(an_fall), .track_tolerance_o(tol), .track_window_ms_o(twin),
    .sensor_pick_mode_o(pick), .sensor_gap_limit_a_o(gapa), .sensor_gap_limit_b_o(gapb));
  vpdo_master_model i_master (.ref_clk_i(clk), .stall_i(stall), .rx_valid_o(rx_valid),
    .rx_id_o(rx_id), .rx_len_o(rx_len), .rx_data_o(rx_data), .tx_valid_i(tx_valid),
    .tx_id_i(tx_id), .tx_len_i(tx_len), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
           input logic err);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    chk("bus answer", pready, 1);
    if (!wr) chk("read data", prdata, exp);
    chk("bus error", pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task frm(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d,
           input logic [63:0] m, output int c);
    int n;
    n = 0;
    while (i_master.id_q.size() == 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("frame wait", n < 5000, 1);
    chk("frame id", i_master.id_q.pop_front(), id);
    chk("frame length", i_master.len_q.pop_front(), len);
    chk("frame data", i_master.dat_q.pop_front() & m, d & m);
    c = i_master.cyc_q.pop_front();
  endtask
  task chain(input int n, input logic [63:0] diag);
    logic [10:0] ids [5];
    int          c;
    int          p;
    ids = '{ID_VT, ID_EFF, ID_CUR, ID_POS, ID_DIAG};
    p = 0;
    for (int k = 0; k < n; k++) begin
      frm(ids[k] + 11'h1, LEN_FULL, k == 4 ? diag : {flt[2*k+1], flt[2*k]}, '1, c);
      if (k > 0) chk("frame gap", c - p >= GAPC - 3 && c - p <= GAPC + 3, 1);
      p = c;
    end
    repeat (GAPC + 10) @(posedge clk);
    chk("chain end", i_master.id_q.size(), 0);
  endtask
  task t_regs;
    apb(0, OFS_CTRL, 0, {24'h0, RST_NODE}, 0);
    apb(0, OFS_TIMEOUT, 0, {16'h0, RST_TIMEOUT}, 0);
    apb(0, OFS_DIAG12, 0, 32'h0090_0000, 0);
    apb(1, OFS_STATUS, 32'hFF, 0, 0);
    apb(0, OFS_STATUS, 0, 32'h208, 0);
    apb(0, 8'h14, 0, 0, 1);
    $display("test regs done");
  endtask
  task t_fast;
    int c;
    i_master.fast(1, 16'h1234, 5'h00, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h08, meas}, '1, c);
    i_master.fast(1, 16'h1234, 5'h02, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h00, meas}, '1, c);
    apb(0, OFS_STATUS, 0, 32'h200, 0);
    i_master.fast(1, 16'h2345, 5'h1B, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h08, meas}, '1, c);
    chk("flags", {demand, trip, an_first, an_fall}, {16'h2345, 3'b111});
    i_master.fast(1, 16'h2345, 5'h02, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h08, meas}, '1, c);
    i_master.fast(1, 16'h5555, 5'h00, 2);
    repeat (6) @(posedge clk);
    chk("short frame", {i_master.id_q.size(), demand}, {32'h0, 16'h2345});
    i_master.fast(1, DEMAND_ZERO, 5'h06, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h18, meas}, '1, c);
    chk("test running", test_run, 1);
    i_master.fast(1, DEMAND_ZERO + 16'h1, 5'h04, 3);
    frm(ID_REPLY + 1, 3, {40'h0, 8'h08, meas}, 64'hFFFF_FFFF, c);
    chk("test running", test_run, 0);
    $display("test fast done");
  endtask
  task t_slow;
    stall <= 1'b1;
    i_master.send(ID_SLOW2 + 1, 8, {32'h3E4C_CCCD, 32'h3DCC_CCCD});
    i_master.send(ID_SLOW1 + 1, 8, {16'h0002, 16'h01F4, 32'h3C23_D70A});
    chain(3, 0);
    chk("slow values", {tol, twin, pick}, {32'h3C23_D70A, 16'h01F4, 2'h2});
    chk("gap limits", {gapb, gapa}, {32'h3E4C_CCCD, 32'h3DCC_CCCD});
    apb(0, OFS_STATUS, 0, 32'h008, 0);
    i_master.send(ID_SLOW1 + 1, 8, {16'h0003, 16'h01F4, 32'h3C23_D70A});
    chain(3, 0);
    chk("pick kept", pick, 2'h2);
    apb(1, OFS_CTRL, 32'h101, 0, 0);
    {fault1, fault2, fault3} <= {11'h401, 16'h0921, 3'h4};
    i_master.send(ID_SLOW1 + 1, 8, {16'h0001, 16'h01F4, 32'h3C23_D70A});
    chain(5, {16'h0, 16'h0004, 16'h0101, 16'h0401});
    chk("pick lower", pick, 2'h1);
    stall <= 1'b0;
    $display("test slow done");
  endtask
  task t_link;
    op_state <= 1'b1;
    apb(1, OFS_TIMEOUT, 32'h2, 0, 0);
    repeat (6 * MSC) @(posedge clk);
    apb(0, OFS_STATUS, 0, 32'h30A, 0);
    $display("test link done");
  endtask
  initial begin
    for (int i = 0; i < 8; i++) flt[i] = 32'h3F80_0000 + i;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_fast;
    t_slow;
    t_link;
    final_report;
  end
  initial begin
    #1000000;
    mismatches++;
    final_report;
  end
endmodule
